//--- hw/c_transfer_regs.vh
// Purpose: constants for the c-register transfer, exchange and clear group
// Assumes: 10-bit instruction words, 56-bit (14 digit) working registers
// Notes:   opcodes are full 10-bit encodings unless marked as a mask
`ifndef C_TRANSFER_REGS_VH
`define C_TRANSFER_REGS_VH

`define OP_LOAD_C_FROM_M     10'h198
`define OP_LOAD_C_FROM_N     10'h0b0
`define OP_LOAD_C_INDIRECT   10'h038
`define OP_REGN_LOW_MASK     10'h03f
`define OP_REGN_LOW_CODE     10'h038
`define REGN_NUM_MSB         9
`define REGN_NUM_LSB         6
`define OP_LOAD_C_FLAG_BYTE  10'h398
`define OP_POP_RETURN_INTO_C 10'h1b0
`define OP_SWAP_C_WITH_G     10'h0d8
`define OP_CHECK_KEYBOARD    10'h3cc
`define OP_CLEAR_THREE       10'h1a0
`define OP_CLEAR_DATA        10'h2b0
`define OP_CLEAR_FLAG_BYTE   10'h3c4
`define OP_SWAP_C_WITH_M     10'h1d8
`define OP_SWAP_C_WITH_N     10'h0f0
`define OP_SET_REG_POINTER   10'h270

`define REG_ADDR_RESET       12'h000
`define FLAG_BYTE_RESET      14'h0000
`define STACK_FILL           16'h0000
`define MSN_DIGIT            4'hd
`define KEY_SLOW_FOLLOWERS   2'h2
`define RD_CS_CYCLES         4'h3
`define SYNC_STAGES          4'h2

`define PTR_EV_NONE          2'h0
`define PTR_EV_TO_MSN        2'h1
`define PTR_EV_FROM_MSN_DEC  2'h2
`define PTR_EV_FROM_MSN_SET  2'h3

`endif

//--- hw/return_stack.v
// Purpose: four-entry return stack with pop into a 16-bit word
// Assumes: push and pop never requested in the same cycle by the owner
// Notes:   pop shifts entries up and fills the bottom with zero
`include "c_transfer_regs.vh"
module return_stack
#(
   parameter WIDTH = 16,
   parameter DEPTH = 4
)
(
   input  wire             ref_clk,
   input  wire             sys_rst,
   input  wire             push,
   input  wire [WIDTH-1:0] push_data,
   input  wire             pop,
   output wire [WIDTH-1:0] top_return_entry
);
   reg [WIDTH-1:0] entry [0:DEPTH-1];
   genvar i;

   assign top_return_entry = entry[0];

   generate
      for (i = 0; i < DEPTH; i = i + 1)
      begin : g_entry
         always @(posedge ref_clk)
         begin
            if (sys_rst)
               entry[i] <= {WIDTH{1'b0}};
            else if (pop)
               entry[i] <= (i == DEPTH - 1) ? `STACK_FILL : entry[(i + 1) % DEPTH]; // [RULE_07]
            else if (push)
               entry[i] <= (i == 0) ? push_data : entry[(i + DEPTH - 1) % DEPTH];
         end
      end
   endgenerate
endmodule // return_stack

//--- hw/reg_read_port.v
// Purpose: reads one data register over the parallel memory bus
// Assumes: memory answers within RD_CYCLES with ram select held low
// Notes:   the data bus is never driven by this port
`include "c_transfer_regs.vh"
module reg_read_port
#(
   parameter DW        = 56,
   parameter AW        = 12,
   parameter RD_CYCLES = `RD_CS_CYCLES
)
(
   input  wire          ref_clk,
   input  wire          sys_rst,
   input  wire          start,
   input  wire [AW-1:0] addr,
   input  wire [DW-1:0] data_bus_in,
   output wire [DW-1:0] data_bus_out,
   output wire          data_bus_oe,
   output reg           ram_cs_n,
   output reg  [AW-1:0] mem_addr,
   output reg           done,
   output reg  [DW-1:0] data
);
   reg [DW-1:0] bus_meta;
   reg [DW-1:0] bus_sync;
   reg [3:0]    count;
   reg          active;

   // reads only: bus left floating so a device outside may answer
   assign data_bus_out = {DW{1'b0}};
   assign data_bus_oe  = 1'b0; // [RULE_03]

   always @(posedge ref_clk)
   begin
      bus_meta <= data_bus_in;
      bus_sync <= bus_meta;
   end

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         ram_cs_n <= 1'b1;
         mem_addr <= {AW{1'b0}};
         done     <= 1'b0;
         data     <= {DW{1'b0}};
         count    <= 4'h0;
         active   <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start && !active)
         begin
            active   <= 1'b1;
            ram_cs_n <= 1'b0; // [RULE_02]
            mem_addr <= addr;
            count    <= 4'h0;
         end
         else if (active)
         begin
            count <= count + 4'h1;
            if (count == RD_CYCLES - 4'h1)
               ram_cs_n <= 1'b1;
            // sample after the two synchroniser stages have caught up
            if (count == RD_CYCLES + `SYNC_STAGES - 4'h1)
            begin
               data   <= bus_sync;
               done   <= 1'b1;
               active <= 1'b0;
            end
         end
      end
   end
endmodule // reg_read_port

//--- hw/c_transfer_exec.v
// Purpose: executes the c-register transfer, exchange and clear instructions
// Assumes: instr is offered with instr_valid and taken when busy is low;
//          key_pressed_flag and flag inputs come from logic on ref_clk
// Notes:   register reads stall the group until the memory bus returns
`include "c_transfer_regs.vh"
// Function
// RULE_01: numbered load keeps pointer high, replaces low nibble
// RULE_02: register reads use parallel bus with ram select
// RULE_03: unimplemented address leaves data bus undriven
// RULE_04: register number zero decodes as indirect load
// RULE_05: turbo: slow only for unimplemented or peripheral register
// RULE_06: flag byte clear zeroes bits 7..0 only
// RULE_07: stack pop loads digits 6..3, shifts, zero fills
// RULE_08: g swap at top nibble uses digits 13, 0
// RULE_09: g swap boundary cases mimic serial datapath
// RULE_10: keyboard check copies key flag into carry
// RULE_11: keyboard check plus next two run slow
// RULE_12: data clear only clears carry, touches no memory
// RULE_13: data clear always runs at bus speed
// RULE_14: triple clear zeroes a, b, c and carry
// RULE_15: m swap exchanges both, clears carry, runs slow
// RULE_16: pointer load takes low three digits of c
// RULE_17: m, n loads and n swap clear carry
// RULE_18: flag byte load fills c digits 1, 0
module c_transfer_exec
#(
   parameter IMPL_LIMIT = 12'h200,
   parameter RD_CYCLES  = `RD_CS_CYCLES
)
(
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire        instr_valid,
   input  wire [9:0]  instr,
   input  wire        turbo_en,
   input  wire        periph_active,
   input  wire        key_pressed_flag,
   input  wire [3:0]  ptr,
   input  wire [1:0]  ptr_event,
   input  wire        push_return,
   input  wire [15:0] push_return_data,
   input  wire [55:0] data_bus_in,
   output wire [55:0] data_bus_out,
   output wire        data_bus_oe,
   output wire        ram_cs_n,
   output wire [11:0] mem_addr,
   output wire        busy,
   output wire        bus_speed,
   output reg         done,
   output reg  [55:0] a_reg,
   output reg  [55:0] b_reg,
   output reg  [55:0] c_reg,
   output reg  [55:0] m_reg,
   output reg  [55:0] n_reg,
   output reg  [7:0]  g_reg,
   output reg  [13:0] flag_byte,
   output reg  [11:0] reg_addr,
   output reg         carry
);
   localparam ST_IDLE = 1'b0;
   localparam ST_READ = 1'b1;

   reg        state;
   reg [1:0]  slow_left;
   reg [55:0] next_c;
   reg [7:0]  next_g;
   reg [11:0] next_addr;
   reg        rd_start;
   wire       rd_done;
   wire [55:0] rd_data;
   wire [15:0] top_return_entry;
   wire        take;
   wire        pop;
   wire        forced_slow;
   wire        read_slow;
   integer     i;

   function is_op;
      input [9:0] word;
      input [9:0] code;
      begin
         is_op = (word == code);
      end
   endfunction

   function is_regn;
      input [9:0] word;
      begin
         is_regn = ((word & `OP_REGN_LOW_MASK) == `OP_REGN_LOW_CODE);
      end
   endfunction

   function unimpl;
      input [11:0] addr;
      begin
         unimpl = (addr >= IMPL_LIMIT);
      end
   endfunction

   // a request offered while busy is dropped, not queued
   assign take = instr_valid && (state == ST_IDLE);
   assign busy = (state != ST_IDLE);
   assign pop  = take && is_op(instr, `OP_POP_RETURN_INTO_C);

   // pointer the read would use; zero number means indirect load
   always @*
   begin
      if (instr[`REGN_NUM_MSB:`REGN_NUM_LSB] == 4'h0)
         next_addr = reg_addr; // [RULE_04]
      else
         next_addr = {reg_addr[11:4], instr[`REGN_NUM_MSB:`REGN_NUM_LSB]}; // [RULE_01]
   end

   // opcodes that turbo never speeds up, whatever the register address
   assign forced_slow = is_op(instr, `OP_CLEAR_DATA) // [RULE_13]
                     || is_op(instr, `OP_SWAP_C_WITH_M) // [RULE_15]
                     || is_op(instr, `OP_CHECK_KEYBOARD); // [RULE_11]

   // unimplemented addresses still complete; only the speed differs
   assign read_slow = is_regn(instr) && (unimpl(next_addr) || periph_active); // [RULE_05]

   // bus speed request for the offered instruction
   // the scanner runs at bus speed, so the window after a key check must too
   assign bus_speed = !turbo_en
                   || (instr_valid && forced_slow)
                   || (instr_valid && slow_left != 2'h0) // [RULE_11]
                   || (instr_valid && read_slow); // [RULE_05]

   // c/g exchange with the serial datapath quirks at the top nibble
   always @*
   begin
      next_c = c_reg;
      next_g = g_reg;
      if (ptr == `MSN_DIGIT)
      begin
         case (ptr_event)
            `PTR_EV_NONE:
            begin
               next_c[55:52] = g_reg[7:4]; // [RULE_08]
               next_c[3:0]   = g_reg[3:0]; // [RULE_08]
               next_g        = {c_reg[55:52], c_reg[3:0]}; // [RULE_08]
            end
            `PTR_EV_TO_MSN:
            begin
               // upper half has not shifted in yet, only one nibble moves
               next_c[55:52] = g_reg[3:0]; // [RULE_09]
               next_g        = {4'h0, c_reg[55:52]}; // [RULE_09]
            end
            default:
            begin
               next_c[55:52] = g_reg[7:4];
               next_c[3:0]   = g_reg[3:0];
               next_g        = {c_reg[55:52], c_reg[3:0]};
            end
         endcase
      end
      else
      begin
         // pointer values 14 and 15 match no digit and leave both alone
         for (i = 0; i < 13; i = i + 1)
         begin
            if (ptr == i[3:0])
            begin
               next_c[4*i +: 8] = g_reg;
               next_g           = c_reg[4*i +: 8];
            end
         end
         // leaving the top nibble leaves g's low nibble on digit 0 too
         if (ptr < `MSN_DIGIT && ptr_event != `PTR_EV_NONE && ptr_event != `PTR_EV_TO_MSN)
            next_c[3:0] = g_reg[3:0]; // [RULE_09]
      end
   end

   always @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state     <= ST_IDLE;
         slow_left <= 2'h0;
         done      <= 1'b0;
         rd_start  <= 1'b0;
         a_reg     <= 56'h0;
         b_reg     <= 56'h0;
         c_reg     <= 56'h0;
         m_reg     <= 56'h0;
         n_reg     <= 56'h0;
         g_reg     <= 8'h00;
         flag_byte <= `FLAG_BYTE_RESET;
         reg_addr  <= `REG_ADDR_RESET;
         carry     <= 1'b0;
      end
      else
      begin
         done     <= 1'b0;
         rd_start <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (take)
               begin
                  carry <= 1'b0;
                  done  <= 1'b1;
                  // a key check inside the window restarts it
                  if (is_op(instr, `OP_CHECK_KEYBOARD))
                     slow_left <= `KEY_SLOW_FOLLOWERS; // [RULE_11]
                  else if (slow_left != 2'h0)
                     slow_left <= slow_left - 2'h1; // [RULE_11]
                  if (is_regn(instr))
                  begin
                     reg_addr <= next_addr; // [RULE_01]
                     rd_start <= 1'b1; // [RULE_02]
                     state    <= ST_READ;
                     done     <= 1'b0;
                  end
                  else if (is_op(instr, `OP_LOAD_C_FROM_M))
                     c_reg <= m_reg; // [RULE_17]
                  else if (is_op(instr, `OP_LOAD_C_FROM_N))
                     c_reg <= n_reg; // [RULE_17]
                  else if (is_op(instr, `OP_SWAP_C_WITH_N))
                  begin
                     c_reg <= n_reg; // [RULE_17]
                     n_reg <= c_reg; // [RULE_17]
                  end
                  else if (is_op(instr, `OP_SWAP_C_WITH_M))
                  begin
                     c_reg <= m_reg; // [RULE_15]
                     m_reg <= c_reg; // [RULE_15]
                  end
                  else if (is_op(instr, `OP_LOAD_C_FLAG_BYTE))
                     c_reg[7:0] <= flag_byte[7:0]; // [RULE_18]
                  else if (is_op(instr, `OP_CLEAR_FLAG_BYTE))
                     flag_byte[7:0] <= 8'h00; // [RULE_06]
                  else if (is_op(instr, `OP_POP_RETURN_INTO_C))
                     c_reg[27:12] <= top_return_entry; // [RULE_07]
                  else if (is_op(instr, `OP_SWAP_C_WITH_G))
                  begin
                     c_reg <= next_c; // [RULE_08]
                     g_reg <= next_g; // [RULE_08]
                  end
                  else if (is_op(instr, `OP_CHECK_KEYBOARD))
                     carry <= key_pressed_flag; // [RULE_10]
                  else if (is_op(instr, `OP_CLEAR_THREE))
                  begin
                     a_reg <= 56'h0; // [RULE_14]
                     b_reg <= 56'h0; // [RULE_14]
                     c_reg <= 56'h0; // [RULE_14]
                  end
                  else if (is_op(instr, `OP_SET_REG_POINTER))
                     reg_addr <= c_reg[11:0]; // [RULE_16]
                  else if (is_op(instr, `OP_CLEAR_DATA))
                  begin
                     // storage is plain ram here, so no cycle reaches it
                     carry <= 1'b0; // [RULE_12]
                  end
               end
            end
            ST_READ:
            begin
               // carry was already cleared at the take edge
               if (rd_done)
               begin
                  c_reg <= rd_data; // [RULE_02]
                  done  <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   return_stack #(
      .WIDTH (16),
      .DEPTH (4)
   ) u_stack (
      .ref_clk          (ref_clk),
      .sys_rst          (sys_rst),
      .push             (push_return && !pop),
      .push_data        (push_return_data),
      .pop              (pop),
      .top_return_entry (top_return_entry)
   );

   reg_read_port #(
      .DW        (56),
      .AW        (12),
      .RD_CYCLES (RD_CYCLES)
   ) u_read (
      .ref_clk      (ref_clk),
      .sys_rst      (sys_rst),
      .start        (rd_start),
      .addr         (reg_addr),
      .data_bus_in  (data_bus_in),
      .data_bus_out (data_bus_out),
      .data_bus_oe  (data_bus_oe),
      .ram_cs_n     (ram_cs_n),
      .mem_addr     (mem_addr),
      .done         (rd_done),
      .data         (rd_data)
   );
endmodule // c_transfer_exec

//--- bench/ram_model.sv
// Purpose: parallel data ram and outside device answering register reads
// Assumes: read word is a fixed pattern of the address
// Notes:   word held one cycle after deselect, then inverted
module ram_model
(
   input  wire logic        ref_clk,
   input  wire logic        ram_cs_n,
   input  wire logic [11:0] mem_addr,
   output logic      [55:0] data_bus_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [55:0] last = 56'h0;
   logic        hold = 1'b0;

   function automatic logic [55:0] word(input logic [11:0] a);
      word = {8'h5a, ~a, a, ~a, a + 12'h123};
   endfunction

   always @(posedge ref_clk)
   begin
      hold <= !ram_cs_n;
      if (!ram_cs_n)
         last <= word(mem_addr);
   end

   // stale word held one cycle once released, then inverted: the simulator must not see a kind zero
   assign data_bus_in = !ram_cs_n ? word(mem_addr) : (hold ? last : ~last);
endmodule // ram_model

//--- bench/c_transfer_exec_asserts.sv
// Purpose: concurrent checks on the c-register transfer group ports
// Assumes: default chip-select length of three cycles
// Notes:   bound into c_transfer_exec below
`include "c_transfer_regs.vh"
module c_transfer_exec_asserts
#(
   parameter IMPL_LIMIT = 12'h200,
   parameter RD_CYCLES  = 3
)
(
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        instr_valid,
   input wire [9:0]  instr,
   input wire        turbo_en,
   input wire        data_bus_oe,
   input wire        ram_cs_n,
   input wire        busy,
   input wire        bus_speed,
   input wire        done,
   input wire [55:0] a_reg,
   input wire [55:0] b_reg,
   input wire [55:0] c_reg,
   input wire [55:0] m_reg,
   input wire [13:0] flag_byte,
   input wire [11:0] reg_addr,
   input wire        carry,
   input wire        key_pressed_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire        take = instr_valid && !busy;
   wire        rd   = instr[5:0] == 6'h38;
   logic [1:0] slow_left;

   always @(posedge ref_clk)
      if (sys_rst)
         slow_left <= 2'h0;
      else if (take && instr == `OP_CHECK_KEYBOARD)
         slow_left <= 2'h2;
      else if (take && slow_left != 2'h0)
         slow_left <= slow_left - 2'h1;

   sequence s_read_take;
      take && rd;
   endsequence
   sequence s_select_window;
      !ram_cs_n [*3] ##1 ram_cs_n;
   endsequence

   a_read_cycle: assert property (s_read_take |-> ##2 s_select_window ##3 done)
      else $error("register read select or completion out of step");
   a_bus_released: assert property (!data_bus_oe)
      else $error("data bus driven");
   a_ptr_nibble: assert property (s_read_take ##0 instr[9:6] != 4'h0 |=>
      reg_addr == {$past(reg_addr[11:4]), $past(instr[9:6])})
      else $error("numbered pointer wrong");
   a_indirect_ptr: assert property (take && instr == `OP_LOAD_C_INDIRECT |=> $stable(reg_addr))
      else $error("indirect load moved pointer");
   a_key_carry: assert property (take && instr == `OP_CHECK_KEYBOARD |=> carry == $past(key_pressed_flag))
      else $error("key flag not copied to carry");
   a_key_slow: assert property (instr_valid && turbo_en && (slow_left != 2'h0 || instr == `OP_CHECK_KEYBOARD)
      |-> bus_speed)
      else $error("keyboard window not at bus speed");
   a_always_slow: assert property (take && (instr == `OP_CLEAR_DATA || instr == `OP_SWAP_C_WITH_M) |-> bus_speed)
      else $error("forced bus speed missing");
   a_carry_clear: assert property (take && !rd && instr != `OP_CHECK_KEYBOARD |=> !carry)
      else $error("carry not cleared");
   a_three_clear: assert property (take && instr == `OP_CLEAR_THREE |=> a_reg == 56'h0 && b_reg == 56'h0 && c_reg == 56'h0)
      else $error("triple clear left data");
   a_flag_low: assert property (take && instr == `OP_CLEAR_FLAG_BYTE |=> flag_byte[7:0] == 8'h0 && $stable(flag_byte[13:8]))
      else $error("flag byte clear wrong");
   a_m_swap: assert property (take && instr == `OP_SWAP_C_WITH_M |=> c_reg == $past(m_reg) && m_reg == $past(c_reg))
      else $error("c and m not exchanged");
   a_no_mem_clear: assert property (take && instr == `OP_CLEAR_DATA |=> ram_cs_n [*2])
      else $error("data clear touched memory");
endmodule // c_transfer_exec_asserts

bind c_transfer_exec c_transfer_exec_asserts #(.IMPL_LIMIT(IMPL_LIMIT), .RD_CYCLES(RD_CYCLES)) i_asserts
(
   .ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr), .turbo_en(turbo_en),
   .data_bus_oe(data_bus_oe), .ram_cs_n(ram_cs_n), .busy(busy), .bus_speed(bus_speed), .done(done),
   .a_reg(a_reg), .b_reg(b_reg), .c_reg(c_reg), .m_reg(m_reg), .flag_byte(flag_byte), .reg_addr(reg_addr),
   .carry(carry), .key_pressed_flag(key_pressed_flag)
);

//--- bench/tb_c_transfer_exec.sv
// Purpose: self-checking bench for c_transfer_exec
// Assumes: default read length, implemented limit 12'h200
// Notes:   turbo stays on; instructions spaced by idle cycles
`include "c_transfer_regs.vh"
module tb_c_transfer_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        sys_rst, instr_valid, turbo_en, periph_active, key_pressed_flag, push_return;
   logic [9:0]  instr;
   logic [3:0]  ptr;
   logic [1:0]  ptr_event;
   logic [15:0] push_return_data;
   logic [55:0] x;
   logic [7:0]  g, gn;
   wire  [55:0] data_bus_in, data_bus_out, a_reg, b_reg, c_reg, m_reg, n_reg;
   wire  [11:0] mem_addr, reg_addr;
   wire  [13:0] flag_byte;
   wire  [7:0]  g_reg;
   wire         data_bus_oe, ram_cs_n, busy, bus_speed, done, carry;
   int          miscompares = 0, comparisons = 0, cycles = 0;
   // row: opcode, key flag, slow, c kind (0 zero, 1 x, 2 x with low byte zero), carry
   logic [14:0] rows [12] = '{{`OP_CHECK_KEYBOARD, 5'h1b}, {`OP_SWAP_C_WITH_M, 5'h18}, {`OP_LOAD_C_FROM_M, 5'h1a},
      {`OP_SWAP_C_WITH_N, 5'h10}, {`OP_LOAD_C_FROM_N, 5'h12}, {`OP_CHECK_KEYBOARD, 5'h1b},
      {`OP_CHECK_KEYBOARD, 5'h0a}, {`OP_CHECK_KEYBOARD, 5'h1b}, {`OP_CLEAR_DATA, 5'h1a},
      {`OP_LOAD_C_FLAG_BYTE, 5'h1c}, {`OP_CLEAR_FLAG_BYTE, 5'h14}, {`OP_CLEAR_THREE, 5'h10}};

   c_transfer_exec i_dut
   (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr), .turbo_en(turbo_en),
      .periph_active(periph_active), .key_pressed_flag(key_pressed_flag), .ptr(ptr), .ptr_event(ptr_event),
      .push_return(push_return), .push_return_data(push_return_data), .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .ram_cs_n(ram_cs_n), .mem_addr(mem_addr), .busy(busy),
      .bus_speed(bus_speed), .done(done), .a_reg(a_reg), .b_reg(b_reg), .c_reg(c_reg), .m_reg(m_reg),
      .n_reg(n_reg), .g_reg(g_reg), .flag_byte(flag_byte), .reg_addr(reg_addr), .carry(carry)
   );
   ram_model i_ram (.ref_clk(ref_clk), .ram_cs_n(ram_cs_n), .mem_addr(mem_addr), .data_bus_in(data_bus_in));

   always #5 ref_clk = ~ref_clk;

   // the whole run needs well under a thousand cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         test_done();
      end
   end

   task automatic check(input logic [55:0] seen, input logic [55:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [55:0] pat(input logic [11:0] a);
      pat = {8'h5a, ~a, a, ~a, a + 12'h123};
   endfunction

   task automatic exec(input logic [9:0] op, input logic slow);
      @(posedge ref_clk);
      instr <= op;
      instr_valid <= 1'b1;
      #1;
      check(56'(bus_speed), 56'(slow));
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
      for (int i = 0; i < 12 && done !== 1'b1; i++)
         @(posedge ref_clk) #1;
      check(56'(done), 56'h1);
   endtask

   task automatic rd(input logic [3:0] n, input logic [11:0] a, input logic slow);
      exec({n, 6'h38}, slow);
      x = pat(a);
      check(56'(reg_addr), 56'(a));
      check(56'(mem_addr), 56'(a));
      check(56'(busy), 56'h0);
      check(c_reg, x);
   endtask

   task automatic gsw(input logic [3:0] p, input logic [1:0] ev);
      @(posedge ref_clk);
      ptr <= p;
      ptr_event <= ev;
      exec(`OP_SWAP_C_WITH_G, 1'b0);
      check(c_reg, x);
      check(56'(g_reg), 56'(gn));
      g = gn;
   endtask

   initial
   begin
      {sys_rst, instr_valid, turbo_en, periph_active, key_pressed_flag, push_return} = 6'h28;
      {instr, ptr, ptr_event, push_return_data} = 32'h0;
      g = 8'h0;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      check(c_reg, 56'h0);
      check(56'(ram_cs_n), 56'h1);
      rd(4'h5, 12'h005, 1'b0);
      foreach (rows[i])
      begin
         @(posedge ref_clk);
         key_pressed_flag <= rows[i][4];
         exec(rows[i][14:5], rows[i][3]);
         check(c_reg, rows[i][2:1] == 2'h0 ? 56'h0 : rows[i][1] ? x : {x[55:8], 8'h0});
         check(56'(carry), 56'(rows[i][0]));
      end
      check(m_reg, x);
      check(n_reg, x);
      rd(4'h5, 12'h005, 1'b0);
      exec(`OP_SET_REG_POINTER, 1'b0);
      check(56'(reg_addr), 56'h128);
      rd(4'h0, 12'h128, 1'b0);
      rd(4'hf, 12'h12f, 1'b0);
      @(posedge ref_clk);
      periph_active <= 1'b1;
      rd(4'h3, 12'h123, 1'b1);
      @(posedge ref_clk);
      periph_active <= 1'b0;
      exec(`OP_SET_REG_POINTER, 1'b0);
      rd(4'h9, 12'h249, 1'b1);
      check(56'(data_bus_oe), 56'h0);
      check(data_bus_out, 56'h0);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         push_return <= 1'b1;
         push_return_data <= 16'h1111 * 16'(i + 1);
      end
      @(posedge ref_clk);
      push_return <= 1'b0;
      // fifth pop shows the zero fill at the bottom
      for (int i = 4; i >= 0; i--)
      begin
         exec(`OP_POP_RETURN_INTO_C, 1'b0);
         x[27:12] = 16'h1111 * 16'(i);
         check(c_reg, x);
      end
      gn = x[11:4];
      x[11:4] = g;
      gsw(4'h1, 2'h0);
      gn = {x[55:52], x[3:0]};
      {x[55:52], x[3:0]} = g;
      gsw(4'hd, 2'h0);
      gn = {4'h0, x[55:52]};
      x[55:52] = g[3:0];
      gsw(4'hd, 2'h1);
      // pointer just left the top nibble: pair swap plus digit 0 from g
      gn = x[55:48];
      x[55:48] = g;
      x[3:0] = g[3:0];
      gsw(4'hc, 2'h2);
      test_done();
   end
endmodule // tb_c_transfer_exec
